// File: design/tap_map.vh
`ifndef TAP_MAP_VH
`define TAP_MAP_VH

// Scan register sizes
`define IR_W         8
`define ID_W         32
`define BSR_W        113

// Instruction codes
`define OP_EXTEST    8'h00
`define OP_IDCODE    8'h21
`define OP_SAMPLE    8'h05
`define OP_CLAMP     8'h07
`define OP_HIGHZ     8'h03
`define OP_BYPASS    8'hFF

// Pattern loaded into the instruction shifter at capture
`define IR_CAPTURE   8'h01
// Value captured by the bypass cell
`define BYP_CAPTURE  1'b0

// Bit positions of the one-hot controller state
`define ST_TLR       0
`define ST_RTI       1
`define ST_SELDR     2
`define ST_CAPDR     3
`define ST_SHDR      4
`define ST_EX1DR     5
`define ST_PDR       6
`define ST_EX2DR     7
`define ST_UPDR      8
`define ST_SELIR     9
`define ST_CAPIR     10
`define ST_SHIR      11
`define ST_EX1IR     12
`define ST_PIR       13
`define ST_EX2IR     14
`define ST_UPIR      15
`define ST_W         16

`endif

// File: design/tap_fsm.v
`timescale 1ns/100ps
`default_nettype none
`include "tap_map.vh"

module tap_fsm
(
   input  wire              clk,
   input  wire              resetn,
   input  wire              clk_en,
   input  wire              tck_rise,
   input  wire              tms,
   output reg  [`ST_W-1:0]  state_r
);

   localparam [15:0] S_TLR   = 16'h0001;
   localparam [15:0] S_RTI   = 16'h0002;
   localparam [15:0] S_SELDR = 16'h0004;
   localparam [15:0] S_CAPDR = 16'h0008;
   localparam [15:0] S_SHDR  = 16'h0010;
   localparam [15:0] S_EX1DR = 16'h0020;
   localparam [15:0] S_PDR   = 16'h0040;
   localparam [15:0] S_EX2DR = 16'h0080;
   localparam [15:0] S_UPDR  = 16'h0100;
   localparam [15:0] S_SELIR = 16'h0200;
   localparam [15:0] S_CAPIR = 16'h0400;
   localparam [15:0] S_SHIR  = 16'h0800;
   localparam [15:0] S_EX1IR = 16'h1000;
   localparam [15:0] S_PIR   = 16'h2000;
   localparam [15:0] S_EX2IR = 16'h4000;
   localparam [15:0] S_UPIR  = 16'h8000;

   reg [15:0] state_nxt;

   // Sixteen-state walk steered by TMS
   always @*
   begin
      case (state_r)
         S_TLR:   state_nxt = tms ? S_TLR   : S_RTI;   // see RULE13
         S_RTI:   state_nxt = tms ? S_SELDR : S_RTI;
         S_SELDR: state_nxt = tms ? S_SELIR : S_CAPDR;
         S_CAPDR: state_nxt = tms ? S_EX1DR : S_SHDR;
         S_SHDR:  state_nxt = tms ? S_EX1DR : S_SHDR;
         S_EX1DR: state_nxt = tms ? S_UPDR  : S_PDR;
         S_PDR:   state_nxt = tms ? S_EX2DR : S_PDR;
         S_EX2DR: state_nxt = tms ? S_UPDR  : S_SHDR;
         S_UPDR:  state_nxt = tms ? S_SELDR : S_RTI;
         S_SELIR: state_nxt = tms ? S_TLR   : S_CAPIR;
         S_CAPIR: state_nxt = tms ? S_EX1IR : S_SHIR;
         S_SHIR:  state_nxt = tms ? S_EX1IR : S_SHIR;
         S_EX1IR: state_nxt = tms ? S_UPIR  : S_PIR;
         S_PIR:   state_nxt = tms ? S_EX2IR : S_PIR;
         S_EX2IR: state_nxt = tms ? S_UPIR  : S_SHIR;
         S_UPIR:  state_nxt = tms ? S_SELDR : S_RTI;
         default: state_nxt = S_TLR;
      endcase
   end

   // Advance on each rising test clock
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         state_r <= S_TLR;
      else if (clk_en && tck_rise)
         state_r <= state_nxt;   // see RULE13
   end

endmodule // tap_fsm

`default_nettype wire

// File: design/boundary_tap.v
`timescale 1ns/100ps
`default_nettype none
`include "tap_map.vh"

// Function
// RULE1: EXTEST captures ring, scans chain, drives pins
// RULE2: Code 21 loads and scans 32-bit ID
// RULE3: SAMPLE/PRELOAD captures ring, scans chain, pins untouched
// RULE4: CLAMP scans bypass, pins driven from cells
// RULE5: HIGH-Z scans bypass, all outputs released
// RULE6: BYPASS places one-bit register in path
// RULE7: ID, sample, bypass leave pins functional
// RULE8: Boundary chain holds 113 cells in order
// RULE9: Instruction capture loads 01 into LSBs
// RULE10: Reset and Test-Logic-Reset select ID instruction
// RULE11: Controller loads only the six defined codes; code loads any value, undefined ones act as BYPASS
// RULE12: Top cell nearest TDI, cell one nearest TDO
// RULE13: Standard state walk, sample rising, drive falling
// RULE14: Bidirectional balls use input and drive cells
module boundary_tap
#(
   parameter [3:0]  ID_REVISION = 4'h0,      // Arbitrary value
   parameter [15:0] ID_PART     = 16'h0000,  // Arbitrary value
   parameter [10:0] ID_MAKER    = 11'h000    // Arbitrary value
)
(
   input  wire              clk,
   input  wire              resetn,
   input  wire              clk_en,
   input  wire              tck,
   input  wire              tms,
   input  wire              tdi,
   output reg               tdo_r,
   output reg               tdo_oe_r,
   input  wire [`BSR_W-1:0] ring_in,
   input  wire [`BSR_W-1:0] core_out,
   input  wire [`BSR_W-1:0] core_oe,
   output reg  [`BSR_W-1:0] pad_out_r,
   output reg  [`BSR_W-1:0] pad_oe_r
);

   ////////////////////////////////////////////////////////////////////////
   // Helper functions

   // Cell number (1..113) that drives the pad of a bidirectional pair
   function drive_cell;
      input integer n;
      begin
         if (n >= 10 && n <= 27 && !(n >= 18 && n <= 19))
            drive_cell = (n % 2) == 1;
         else if ((n >= 29 && n <= 48) || (n >= 67 && n <= 74) ||
                  (n >= 77 && n <= 104))
            drive_cell = (n % 2) == 0;
         else
            drive_cell = 1'b0;
      end
   endfunction

   // Chain placed between TDI and TDO: 0 bypass, 1 ID, 2 boundary
   function [1:0] dr_sel;
      input [`IR_W-1:0] op;
      begin
         case (op)
            `OP_EXTEST: dr_sel = 2'h2;   // see RULE1
            `OP_SAMPLE: dr_sel = 2'h2;   // see RULE3
            `OP_IDCODE: dr_sel = 2'h1;   // see RULE2
            default:    dr_sel = 2'h0;   // see RULE4, RULE5, RULE6, RULE11
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   reg              tck_s1_r;
   reg              tck_s2_r;
   reg              tck_s3_r;
   reg              tms_s1_r;
   reg              tms_s2_r;
   reg              tdi_s1_r;
   reg              tdi_s2_r;
   reg [`BSR_W-1:0] ring_s1_r;
   reg [`BSR_W-1:0] ring_s2_r;

   // Two stages before any use
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         tck_s1_r  <= 1'b0;
         tck_s2_r  <= 1'b0;
         tck_s3_r  <= 1'b0;
         tms_s1_r  <= 1'b1;
         tms_s2_r  <= 1'b1;
         tdi_s1_r  <= 1'b1;
         tdi_s2_r  <= 1'b1;
         ring_s1_r <= {`BSR_W{1'b0}};
         ring_s2_r <= {`BSR_W{1'b0}};
      end
      else if (clk_en)
      begin
         tck_s1_r  <= tck;
         tck_s2_r  <= tck_s1_r;
         tck_s3_r  <= tck_s2_r;
         tms_s1_r  <= tms;
         tms_s2_r  <= tms_s1_r;
         tdi_s1_r  <= tdi;
         tdi_s2_r  <= tdi_s1_r;
         ring_s1_r <= ring_in;
         ring_s2_r <= ring_s1_r;
      end
   end

   wire tck_rise = tck_s2_r & ~tck_s3_r;
   wire tck_fall = ~tck_s2_r & tck_s3_r;

   ////////////////////////////////////////////////////////////////////////
   // Controller

   wire [`ST_W-1:0] st;

   tap_fsm u_fsm
   (
      .clk      (clk),
      .resetn   (resetn),
      .clk_en   (clk_en),
      .tck_rise (tck_rise),
      .tms      (tms_s2_r),
      .state_r  (st)
   );

   ////////////////////////////////////////////////////////////////////////
   // Instruction register

   reg [`IR_W-1:0] ir_sh_r;
   reg [`IR_W-1:0] ir_r;

   // Capture, shift and update of the instruction
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ir_sh_r <= `IR_CAPTURE;
         ir_r    <= `OP_IDCODE;               // see RULE10
      end
      else if (clk_en)
      begin
         if (st[`ST_TLR])
            ir_r <= `OP_IDCODE;               // see RULE10
         else if (tck_fall && st[`ST_UPIR])
            ir_r <= ir_sh_r;
         if (tck_rise && st[`ST_CAPIR])
            ir_sh_r <= `IR_CAPTURE;           // see RULE9
         else if (tck_rise && st[`ST_SHIR])
            ir_sh_r <= {tdi_s2_r, ir_sh_r[`IR_W-1:1]};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Data registers

   reg              byp_r;
   reg [`ID_W-1:0]  id_r;
   reg [`BSR_W-1:0] bsr_r;
   reg [`BSR_W-1:0] bsr_upd_r;

   wire [1:0] sel = dr_sel(ir_r);
   wire cap_dr = tck_rise & st[`ST_CAPDR];
   wire sh_dr  = tck_rise & st[`ST_SHDR];

   // Bypass cell
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         byp_r <= `BYP_CAPTURE;
      else if (clk_en && sel == 2'h0)
      begin
         if (cap_dr)
            byp_r <= `BYP_CAPTURE;
         else if (sh_dr)
            byp_r <= tdi_s2_r;                // see RULE6
      end
   end

   // Identification shifter
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         id_r <= {`ID_W{1'b0}};
      else if (clk_en && sel == 2'h1)
      begin
         if (cap_dr)
            id_r <= {ID_REVISION, ID_PART, ID_MAKER, 1'b1};   // see RULE2
         else if (sh_dr)
            id_r <= {tdi_s2_r, id_r[`ID_W-1:1]};
      end
   end

   // Boundary chain: cell n sits at bit n-1, TDI enters at the top
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         bsr_r     <= {`BSR_W{1'b0}};
         bsr_upd_r <= {`BSR_W{1'b0}};
      end
      else if (clk_en && sel == 2'h2)
      begin
         if (cap_dr)
            bsr_r <= ring_s2_r;                // see RULE1, RULE3
         else if (sh_dr)
            bsr_r <= {tdi_s2_r, bsr_r[`BSR_W-1:1]};   // see RULE8, RULE12
         if (tck_fall && st[`ST_UPDR])
            bsr_upd_r <= bsr_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Serial output, changed on falling test clock

   reg tdo_nxt;

   // Least significant bit of the selected path
   always @*
   begin
      if (st[`ST_SHIR])
         tdo_nxt = ir_sh_r[0];
      else if (sel == 2'h2)
         tdo_nxt = bsr_r[0];                   // see RULE12
      else if (sel == 2'h1)
         tdo_nxt = id_r[0];
      else
         tdo_nxt = byp_r;
   end

   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         tdo_r    <= 1'b0;
         tdo_oe_r <= 1'b0;
      end
      else if (clk_en && tck_fall)
      begin
         tdo_r    <= tdo_nxt;                  // see RULE13
         tdo_oe_r <= st[`ST_SHIR] | st[`ST_SHDR];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pad control

   reg [`BSR_W-1:0] pad_out_nxt;
   reg [`BSR_W-1:0] pad_oe_nxt;
   integer          k;
   // Pick functional, scan-driven or released pads
   always @*
   begin
      k           = 0;
      pad_out_nxt = core_out;                  // see RULE7
      pad_oe_nxt  = core_oe;
      if (ir_r == `OP_EXTEST || ir_r == `OP_CLAMP)
      begin
         for (k = 0; k < `BSR_W; k = k + 1)
         begin
            pad_out_nxt[k] = bsr_upd_r[k];     // see RULE1, RULE4
            // Drive cell of a pair is enabled, its input cell released
            if (drive_cell(k + 1))
               pad_oe_nxt[k] = 1'b1;           // see RULE14
            else if (k + 1 < `BSR_W && drive_cell(k + 2))
               pad_oe_nxt[k] = 1'b0;           // see RULE14
            else
               pad_oe_nxt[k] = 1'b1;
         end
      end
      else if (ir_r == `OP_HIGHZ)
      begin
         pad_oe_nxt = {`BSR_W{1'b0}};          // see RULE5
      end
   end

   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pad_out_r <= {`BSR_W{1'b0}};
         pad_oe_r  <= {`BSR_W{1'b0}};
      end
      else if (clk_en)
      begin
         pad_out_r <= pad_out_nxt;
         pad_oe_r  <= pad_oe_nxt;
      end
   end

endmodule // boundary_tap

`default_nettype wire

// File: bench/boundary_tap_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module boundary_tap_asserts
(
   input wire logic         clk,
   input wire logic         resetn,
   input wire logic         tck,
   input wire logic         tdo_r,
   input wire logic         tdo_oe_r,
   input wire logic [112:0] core_out,
   input wire logic [112:0] core_oe,
   input wire logic [112:0] pad_out_r,
   input wire logic [112:0] pad_oe_r
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   logic [3:0] quiet_r;
   // Counts cycles with no pin activity
   always @(posedge clk or negedge resetn)
      if (!resetn)
         quiet_r <= 4'h0;
      else if (!$stable(tck) || !$stable(core_out) || !$stable(core_oe))
         quiet_r <= 4'h0;
      else if (quiet_r != 4'hF)
         quiet_r <= quiet_r + 4'h1;
   ////////////////////////////////////////////////////////////////////////
   a_tdo_at_fall: assert property (
      $changed(tdo_r) |-> !$past(tck) && !$past(tck, 2))
      else $error("tdo moved while tck high");
   a_oe_at_fall: assert property (
      $changed(tdo_oe_r) |-> !$past(tck) && !$past(tck, 2))
      else $error("tdo enable moved while tck high");
   a_tdo_holds: assert property (
      $changed(tdo_r) |=> $stable(tdo_r) [*5])
      else $error("tdo held too briefly");
   a_oe_holds: assert property (
      $rose(tdo_oe_r) |=> tdo_oe_r [*5])
      else $error("shift window too short");
   a_quiet_pads: assert property (
      quiet_r >= 4'h5 |-> $stable(pad_out_r) && $stable(pad_oe_r))
      else $error("pads moved with no cause");
   a_quiet_tdo: assert property (
      quiet_r >= 4'h5 |-> $stable(tdo_r) && $stable(tdo_oe_r))
      else $error("tdo moved with no tck edge");
   a_reset_func: assert property (
      $rose(resetn) |=> pad_out_r == $past(core_out)
         && pad_oe_r == $past(core_oe))
      else $error("pads not functional after reset");
   a_hiz_values: assert property (
      $past(resetn) && pad_oe_r == '0 && $past(core_oe) != '0
         |-> pad_out_r == $past(core_out))
      else $error("released pads not fed from core");
endmodule // boundary_tap_asserts
bind boundary_tap boundary_tap_asserts boundary_tap_asserts_i
(
   .clk(clk), .resetn(resetn), .tck(tck), .tdo_r(tdo_r),
   .tdo_oe_r(tdo_oe_r), .core_out(core_out), .core_oe(core_oe),
   .pad_out_r(pad_out_r), .pad_oe_r(pad_oe_r)
);
`default_nettype wire

// File: bench/jtag_host.sv
`timescale 1ns/100ps
`default_nettype none
module jtag_host
(
   input  wire logic clk,
   output var  logic tck,
   output var  logic tms,
   output var  logic tdi,
   input  wire logic tdo
);
   logic last;
   // Idle link: clock parked low
   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // One test clock period, four clk per phase
   task automatic tick(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      repeat (4) @(negedge clk);
      o = tdo;
      tck = 1'b1;
      repeat (4) @(negedge clk);
      tck = 1'b0;
   endtask
   // Five ones reach reset, then park in idle
   task automatic to_idle();
      repeat (5) tick(1'b1, ~tdi, last);
      tick(1'b0, ~tdi, last);
   endtask
   // Shift n bits LSB first from idle, back to idle
   task automatic scan(input logic ir, input int n,
                       input logic [127:0] din, output logic [127:0] dout);
      dout = '0;
      tick(1'b1, ~tdi, last);
      if (ir)
         tick(1'b1, ~tdi, last);
      tick(1'b0, ~tdi, last);
      tick(1'b0, ~tdi, last);
      for (int i = 0; i < n; i++)
         tick(i == n - 1, din[i], dout[i]);
      tick(1'b1, ~tdi, last);
      tick(1'b0, ~tdi, last);
      repeat (6) @(negedge clk);
   endtask
endmodule // jtag_host
`default_nettype wire

// File: bench/test_boundary_tap.sv
`timescale 1ns/100ps
`default_nettype none
`include "tap_map.vh"
module test_boundary_tap;
   localparam logic [3:0]   REV   = 4'h3;      // Arbitrary value
   localparam logic [15:0]  PART  = 16'h5AC3;  // Arbitrary value
   localparam logic [10:0]  MAKER = 11'h2B4;   // Arbitrary value
   localparam logic [112:0] PA    = {1'b1, {7{16'hC35A}}};
   localparam logic [112:0] PB    = {1'b0, {7{16'h96E1}}};
   localparam logic [112:0] PC    = {1'b1, {7{16'h0FF0}}};
   logic         clk, resetn, tck, tms, tdi, tdo_r, tdo_oe_r;
   logic [112:0] ring_in, core_out, core_oe, pad_out_r, pad_oe_r;
   logic [127:0] got;
   int           n_fail = 0;
   int           num_checks = 0;
   int           cyc = 0;
   ////////////////////////////////////////////////////////////////////////
   boundary_tap #(.ID_REVISION(REV), .ID_PART(PART), .ID_MAKER(MAKER))
   boundary_tap_i (.clk(clk), .resetn(resetn), .clk_en(1'b1), .tck(tck),
      .tms(tms), .tdi(tdi), .tdo_r(tdo_r), .tdo_oe_r(tdo_oe_r),
      .ring_in(ring_in), .core_out(core_out), .core_oe(core_oe),
      .pad_out_r(pad_out_r), .pad_oe_r(pad_oe_r));
   // Released tdo shows the inverse of its last value
   jtag_host jtag_host_i (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi),
      .tdo(tdo_oe_r ? tdo_r : ~tdo_r));
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [127:0] exp,
                        input logic [127:0] seen);
      num_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Identification read, pins functional
   task automatic t_id();
      jtag_host_i.to_idle();
      check("tdo_oe", 1'b0, tdo_oe_r);
      check("pad_out", core_out, pad_out_r);
      check("pad_oe", core_oe, pad_oe_r);
      jtag_host_i.scan(1'b0, 32, '0, got);
      check("idcode", {REV, PART, MAKER, 1'b1}, got[31:0]);
   endtask
   // Instruction capture pattern, then one-stage path
   task automatic t_bypass();
      jtag_host_i.scan(1'b1, 8, `OP_BYPASS, got);
      check("ir_capture", 2'b01, got[1:0]);
      jtag_host_i.scan(1'b0, 8, 8'hB6, got);
      check("bypass", 8'h6C, got[7:0]);
      check("pad_out", core_out, pad_out_r);
   endtask
   // Sample and preload, then drive pins from cells
   task automatic t_boundary();
      jtag_host_i.scan(1'b1, 8, `OP_SAMPLE, got);
      jtag_host_i.scan(1'b0, 113, PB, got);
      check("sample", PA, got[112:0]);
      check("pad_oe", core_oe, pad_oe_r);
      jtag_host_i.scan(1'b1, 8, `OP_EXTEST, got);
      check("preload", PB, pad_out_r);
      check("pair_oe", 2'b10, pad_oe_r[10:9]);
      ring_in = PC;
      jtag_host_i.scan(1'b0, 113, PA, got);
      check("extest", PC, got[112:0]);
      check("drive", PA, pad_out_r);
   endtask
   // Bypass path with pins held, then released
   task automatic t_clamp_hiz();
      jtag_host_i.scan(1'b1, 8, `OP_CLAMP, got);
      // Core moves while clamped; pads must not follow
      core_out = PA ^ PB;
      jtag_host_i.scan(1'b0, 2, 2'b11, got);
      check("clamp_path", 2'b10, got[1:0]);
      check("clamp_out", PA, pad_out_r);
      jtag_host_i.scan(1'b1, 8, `OP_HIGHZ, got);
      jtag_host_i.scan(1'b0, 2, 2'b01, got);
      check("hiz_path", 2'b10, got[1:0]);
      check("hiz_oe", '0, pad_oe_r);
      check("hiz_out", PA ^ PB, pad_out_r);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Clock
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 12000)
      begin
         n_fail++;
         summarize();
      end
   end
   // Main sequence
   initial
   begin
      resetn = 1'b0;
      ring_in = PA;
      core_out = PC ^ PB;
      core_oe = PB | 113'h1;
      repeat (16) @(negedge clk);
      resetn = 1'b1;
      repeat (4) @(negedge clk);
      t_id();
      t_bypass();
      t_boundary();
      t_clamp_hiz();
      t_id();
      summarize();
   end
endmodule // test_boundary_tap
`default_nettype wire
